/* File: core/csp_top.sv */
// cpu status and pin readout register bank on an ahb-lite slave port
//
// What this block does
// - new average equals old average plus current value, halved, same update
// - any nonzero throttle time below one step reads as code one
// - pin level bits read one for a low pin, zero for high, unlatched
// - mode field in the control register picks both identification layouts
// - six-bit mode: cpu one pins 5:0 in bits 5:0, bits 7:6 zero
// - seven-bit and newer first modes: cpu one pins 6:0, bit 7 zero
// - newer second mode: cpu one pins 7:1 in bits 7:1, bit 0 zero
// - identification registers update only after pins hold steady 600 ns
// - cpu two uses same layouts; six-bit mode pins 5:0, upper zero
// - seven-bit mode: cpu two pins 6:0 in bits 6:0, bit 7 zero
// - current throttle loads at interval end; average updates the same instant
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "csp_map.svh"
module csp_top #(
  parameter int VID_STABLE_CYC = `CSP_VID_STABLE_CYC
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // throttle interval measurement
  input  wire logic               thr_load,
  input  wire csp_pkg::csp_byte_t thr_code,
  input  wire logic               thr_nonzero,
  // pins
  input  wire logic [7:0]         gpio_pins,
  input  wire logic [7:0]         cpu1_vid_pins,
  input  wire logic [7:0]         cpu2_vid_pins
);
  import csp_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (VID_STABLE_CYC < 1) begin : g_bad
    $error("csp_top: VID_STABLE_CYC must be at least 1");
  end

  // ************************************************************
  // register state
  // ************************************************************
  csp_byte_t     cur_thr2;
  csp_byte_t     avg_cpu2_throttle_pct;
  csp_byte_t     input_pin_levels;
  csp_byte_t     cpu1_voltage_ident;
  csp_byte_t     cpu2_voltage_ident;
  csp_vid_mode_e vid_mode;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [7:0] gpio_s1;
  logic [7:0] gpio_s2;
  logic [7:0] vid1_s1;
  logic [7:0] vid1_s2;
  logic [7:0] vid2_s1;
  logic [7:0] vid2_s2;
  logic [7:0] vid1_stable;
  logic [7:0] vid2_stable;

  // first stage feeds only the second; pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gpio_s1 <= 8'hff;
      gpio_s2 <= 8'hff;
      vid1_s1 <= 8'h00;
      vid1_s2 <= 8'h00;
      vid2_s1 <= 8'h00;
      vid2_s2 <= 8'h00;
    end else begin
      gpio_s1 <= gpio_pins;
      gpio_s2 <= gpio_s1;
      vid1_s1 <= cpu1_vid_pins;
      vid1_s2 <= vid1_s1;
      vid2_s1 <= cpu2_vid_pins;
      vid2_s2 <= vid2_s1;
    end
  end

  // ************************************************************
  // identification stability filters
  // ************************************************************
  csp_vid_filter #(
    .W (8),
    .N (VID_STABLE_CYC)
  ) u_vid1_filter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pins    (vid1_s2),
    .stable  (vid1_stable)
  );

  csp_vid_filter #(
    .W (8),
    .N (VID_STABLE_CYC)
  ) u_vid2_filter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pins    (vid2_s2),
    .stable  (vid2_stable)
  );

  // ************************************************************
  // layout and throttle helpers
  // ************************************************************
  // place filtered pins by mode; reserved bits read zero
  function automatic csp_byte_t vid_layout(input csp_vid_mode_e m,
                                           input logic [7:0] p);
    csp_byte_t r;
    r = 8'h00;
    case (m)
      six_bit_ident_mode:          r = {2'b00, p[5:0]};
      extended_seven_bit_mode:     r = {1'b0, p[6:0]};
      newer_regulator_first_mode:  r = {1'b0, p[6:0]};
      newer_regulator_second_mode: r = {p[7:1], 1'b0};
      default:                     r = 8'h00;
    endcase
    return r;
  endfunction

  // never let real throttling round down to a zero code
  function automatic csp_byte_t thr_floor(input csp_byte_t v, input logic any);
    return (v == 8'h00 && any) ? `CSP_THR_MIN_CODE : v;
  endfunction

  csp_byte_t next_cur_thr2;
  csp_byte_t next_avg;
  logic [8:0] avg_sum;

  // the sum needs nine bits so the halving never loses the carry
  always_comb begin
    next_cur_thr2 = thr_floor(thr_code, thr_nonzero);
    avg_sum       = {1'b0, avg_cpu2_throttle_pct} + {1'b0, next_cur_thr2};
    next_avg      = thr_floor(avg_sum[8:1], avg_sum != 9'h000);
  end

  // ************************************************************
  // throttle registers
  // ************************************************************
  // current and average move on the same edge at interval end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_thr2              <= `CSP_RST_BYTE;
      avg_cpu2_throttle_pct <= `CSP_RST_BYTE;
    end else if (thr_load) begin
      cur_thr2              <= next_cur_thr2;
      avg_cpu2_throttle_pct <= next_avg;
    end
  end

  // ************************************************************
  // pin level and identification registers
  // ************************************************************
  // pin levels follow the synchronised pins every cycle, inverted
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      input_pin_levels <= `CSP_RST_BYTE;
    end else begin
      input_pin_levels <= ~gpio_s2;
    end
  end

  // layout follows the mode at once; the pins only via the filter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpu1_voltage_ident <= `CSP_RST_BYTE;
      cpu2_voltage_ident <= `CSP_RST_BYTE;
    end else begin
      cpu1_voltage_ident <= vid_layout(vid_mode, vid1_stable);
      cpu2_voltage_ident <= vid_layout(vid_mode, vid2_stable);
    end
  end

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  logic        addr_ok;
  logic        wr_pend;
  logic [31:0] wr_addr;
  csp_byte_t   rd_byte;

  assign addr_ok = hsel && htrans[1] && hready;

  // read decode; unmapped addresses read as zero with an okay response
  always_comb begin
    case (haddr)
      `CSP_ADDR(`CSP_IDX_THR2_CUR):   rd_byte = cur_thr2;
      `CSP_ADDR(`CSP_IDX_THR2_AVG):   rd_byte = avg_cpu2_throttle_pct;
      `CSP_ADDR(`CSP_IDX_PIN_LEVELS): rd_byte = input_pin_levels;
      `CSP_ADDR(`CSP_IDX_CPU1_VID):   rd_byte = cpu1_voltage_ident;
      `CSP_ADDR(`CSP_IDX_CPU2_VID):   rd_byte = cpu2_voltage_ident;
      `CSP_ADDR(`CSP_IDX_MODE_CTRL):  rd_byte = {6'h00, vid_mode};
      default:                        rd_byte = 8'h00;
    endcase
  end

  // zero wait states: read data is captured in the address phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= (addr_ok && !hwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // remember a write until its data phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr;
    end
  end

  // only the mode field is writable; all else here is read-only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vid_mode <= csp_vid_mode_e'(`CSP_RST_MODE);
    end else if (wr_pend && wr_addr == `CSP_ADDR(`CSP_IDX_MODE_CTRL)) begin
      vid_mode <= csp_vid_mode_e'(hwdata[`CSP_MODE_MSB:`CSP_MODE_LSB]);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // pipeline age of gpio, so the three-cycle look-back stays inside reset-free time
  logic [1:0] age;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end

  a_avg_update: assert property (
    thr_load |=> avg_cpu2_throttle_pct ==
      thr_floor(8'(({1'b0, $past(avg_cpu2_throttle_pct)}
                   + {1'b0, $past(next_cur_thr2)}) >> 1),
                ($past(avg_cpu2_throttle_pct) | $past(next_cur_thr2)) != 8'h00))
    else $error("average throttle value wrong after load");

  a_thr_min_code: assert property (
    (thr_load && thr_nonzero) |=> (cur_thr2 != 8'h00 && avg_cpu2_throttle_pct != 8'h00))
    else $error("nonzero throttle time reported as zero");

  a_thr_hold: assert property (
    !thr_load |=> $stable(cur_thr2) && $stable(avg_cpu2_throttle_pct))
    else $error("throttle registers moved without a load");

  a_cur_load: assert property (
    (thr_load && thr_code != 8'h00) |=> cur_thr2 == $past(thr_code))
    else $error("current throttle value not loaded");

  a_pin_invert: assert property (
    (age == 2'h3) |-> input_pin_levels == ~$past(gpio_pins, 3))
    else $error("pin level bits do not follow inverted pins");

  a_sync_depth: assert property (
    ##2 vid1_s2 == $past(cpu1_vid_pins, 2))
    else $error("identification synchroniser depth wrong");

  a_cpu1_six: assert property (
    $past(vid_mode) == six_bit_ident_mode |->
      cpu1_voltage_ident == {2'b00, $past(vid1_stable[5:0])})
    else $error("cpu one six-bit layout wrong");

  a_cpu1_seven: assert property (
    $past(vid_mode) inside {extended_seven_bit_mode, newer_regulator_first_mode} |->
      cpu1_voltage_ident == {1'b0, $past(vid1_stable[6:0])})
    else $error("cpu one seven-bit layout wrong");

  a_cpu1_second: assert property (
    $past(vid_mode) == newer_regulator_second_mode |->
      cpu1_voltage_ident == {$past(vid1_stable[7:1]), 1'b0})
    else $error("cpu one second-mode layout wrong");

  a_cpu2_six: assert property (
    $past(vid_mode) == six_bit_ident_mode |->
      cpu2_voltage_ident == {2'b00, $past(vid2_stable[5:0])})
    else $error("cpu two six-bit layout wrong");

  a_cpu2_seven: assert property (
    $past(vid_mode) == extended_seven_bit_mode |->
      cpu2_voltage_ident == {1'b0, $past(vid2_stable[6:0])})
    else $error("cpu two seven-bit layout wrong");

  // cpu two shares the newer-regulator layouts; reserved bits must stay zero
  a_cpu2_newer: assert property (
    $past(vid_mode) == newer_regulator_first_mode |->
      cpu2_voltage_ident == {1'b0, $past(vid2_stable[6:0])})
    else $error("cpu two newer first-mode layout wrong");

  a_cpu2_second: assert property (
    $past(vid_mode) == newer_regulator_second_mode |->
      cpu2_voltage_ident == {$past(vid2_stable[7:1]), 1'b0})
    else $error("cpu two second-mode layout wrong");

  a_mode_write: assert property (
    (addr_ok && hwrite && haddr == `CSP_ADDR(`CSP_IDX_MODE_CTRL)) ##1 1'b1 |=>
      vid_mode == csp_vid_mode_e'($past(hwdata[1:0])))
    else $error("mode field not taken from write data");

  a_vid_quiet: assert property (
    ($stable(vid1_stable) && $stable(vid_mode)) |=> $stable(cpu1_voltage_ident))
    else $error("identification register moved without a stable update");

  a_read_data: assert property (
    (addr_ok && !hwrite) |=> hrdata[31:8] == 24'h000000 && hreadyout && !hresp)
    else $error("read answer malformed");

  c_thr_load: cover property (thr_load ##1 thr_load);
  c_second_mode: cover property (vid_mode == newer_regulator_second_mode
                                 ##1 $changed(cpu1_voltage_ident));
  c_avg_read: cover property (addr_ok && !hwrite
                              && haddr == `CSP_ADDR(`CSP_IDX_THR2_AVG));
  c_mode_write: cover property (wr_pend
                                && wr_addr == `CSP_ADDR(`CSP_IDX_MODE_CTRL));
endmodule

/* File: core/csp_map.svh */
// offsets, field positions, reset values and timing counts of the cpu status readout
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define CSP_IDX_THR2_CUR   8'h69
`define CSP_IDX_THR2_AVG   8'h6a
`define CSP_IDX_PIN_LEVELS 8'h6b
`define CSP_IDX_CPU1_VID   8'h6c
`define CSP_IDX_CPU2_VID   8'h6d
`define CSP_IDX_MODE_CTRL  8'hbd
`define CSP_ADDR(i)        ({22'h000000, (i), 2'b00})

// ************************************************************
// fields and reset values
// ************************************************************
`define CSP_MODE_LSB       0
`define CSP_MODE_MSB       1
`define CSP_RST_BYTE       8'h00
`define CSP_RST_MODE       2'h0
`define CSP_THR_MIN_CODE   8'h01

// ************************************************************
// timing
// ************************************************************
`define CSP_CLK_PERIOD_NS  25
`define CSP_VID_STABLE_NS  600
// least time, rounded up to whole cycles
`define CSP_VID_STABLE_CYC \
  ((`CSP_VID_STABLE_NS + `CSP_CLK_PERIOD_NS - 1) / `CSP_CLK_PERIOD_NS)
`define CSP_SYNC_STAGES    2

`endif

/* File: core/csp_pkg.sv */
// types shared by the cpu status readout
package csp_pkg;
  // voltage-identification layouts, in the order of the mode field
  typedef enum logic [1:0] {
    six_bit_ident_mode,
    extended_seven_bit_mode,
    newer_regulator_first_mode,
    newer_regulator_second_mode
  } csp_vid_mode_e;
  typedef logic [7:0] csp_byte_t;
endpackage

/* File: core/csp_vid_filter.sv */
// stability filter for one processor's identification pins
`timescale 1ns/1ps
module csp_vid_filter #(
  parameter int W = 8,
  parameter int N = 24
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // synchronised pins in, filtered value out
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] stable
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N);

  logic [W-1:0]  prev;
  logic [CW-1:0] cnt;

  // refuse counts the counter cannot serve
  if (N < 1 || W < 1) begin : g_bad
    $error("csp_vid_filter: N and W must be at least 1");
  end

  // count cycles the pins have held one value
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev <= '0;
      cnt  <= '0;
    end else begin
      prev <= pins;
      if (pins != prev) begin
        cnt <= '0;
      end else if (cnt != LAST) begin
        cnt <= cnt + CW'(1);
      end
    end
  end

  // take the value only once it has held long enough; glitches never land
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stable <= '0;
    end else if (cnt == LAST && pins == prev) begin
      stable <= prev;
    end
  end

  a_glitch_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cnt != LAST) |=> $stable(stable))
    else $error("identification value changed before it was stable");

  a_stable_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cnt == LAST && pins == prev) |=> stable == $past(prev))
    else $error("stable identification value not taken");
endmodule

/* File: sim/csp_pin_model.sv */
// partner model: processor status pins and throttle interval results
`timescale 1ns/1ps
module csp_pin_model (
  // clock
  input  wire logic         clk_sys,
  // throttle interval results
  output logic              thr_load,
  output csp_pkg::csp_byte_t thr_code,
  output logic              thr_nonzero,
  // pins
  output logic [7:0]        gpio_pins,
  output logic [7:0]        cpu1_vid_pins,
  output logic [7:0]        cpu2_vid_pins
);
  import csp_pkg::*;

  // gpio pins idle high so the level register reads zero after reset
  initial begin
    thr_load      = 1'b0;
    thr_code      = 8'h00;
    thr_nonzero   = 1'b0;
    gpio_pins     = 8'hff;
    cpu1_vid_pins = 8'h00;
    cpu2_vid_pins = 8'h00;
  end

  // all pins move together just after an edge, asynchronous to the block
  task automatic set_pins(input logic [7:0] g, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_sys);
    gpio_pins     <= g;
    cpu1_vid_pins <= a;
    cpu2_vid_pins <= b;
  endtask

  // one interval result; hold keeps the strobe up for a back-to-back one
  task automatic strobe(input csp_byte_t c, input logic nz, input bit hold);
    @(posedge clk_sys);
    thr_load    <= 1'b1;
    thr_code    <= c;
    thr_nonzero <= nz;
    if (!hold) begin
      @(posedge clk_sys);
      thr_load    <= 1'b0;
      // stale data is not left standing after the strobe
      thr_code    <= ~c;
      thr_nonzero <= ~nz;
    end
  endtask
endmodule

/* File: sim/tb_cpu_status_pin_readout.sv */
// self-checking bench of the cpu status and pin readout register bank
`timescale 1ns/1ps
`include "csp_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_cpu_status_pin_readout;
  import csp_pkg::*;
  localparam int VSC = 4;
  logic               clk_sys = 1'b0;
  logic               rst_n   = 1'b0;
  logic               hsel    = 1'b0;
  logic               hwrite  = 1'b0;
  logic [1:0]         htrans  = 2'b00;
  logic [2:0]         hsize   = 3'h2;
  logic [31:0]        haddr   = 32'h0;
  logic [31:0]        hwdata  = 32'h0;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic               thr_load;
  logic               thr_nonzero;
  csp_byte_t          thr_code;
  logic [7:0]         gpio_pins;
  logic [7:0]         cpu1_vid_pins;
  logic [7:0]         cpu2_vid_pins;
  logic [31:0]        d;
  csp_byte_t          cur_m = 8'h00;
  csp_byte_t          avg_m = 8'h00;
  int                 fail_count = 0;
  int                 tests_run  = 0;

  // ************************************************************
  // clock, design and partner
  // ************************************************************
  always #12.5 clk_sys = ~clk_sys;

  csp_top #(.VID_STABLE_CYC(VSC)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .thr_load(thr_load),
    .thr_code(thr_code), .thr_nonzero(thr_nonzero), .gpio_pins(gpio_pins),
    .cpu1_vid_pins(cpu1_vid_pins), .cpu2_vid_pins(cpu2_vid_pins));

  csp_pin_model model (
    .clk_sys(clk_sys), .thr_load(thr_load), .thr_code(thr_code),
    .thr_nonzero(thr_nonzero), .gpio_pins(gpio_pins),
    .cpu1_vid_pins(cpu1_vid_pins), .cpu2_vid_pins(cpu2_vid_pins));

  // ************************************************************
  // bus and helpers
  // ************************************************************
  task automatic print_verdict();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("BAD %0t bus timeout", $time);
      print_verdict();
    end
  endtask

  // one single word transfer; read data taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= `CSP_ADDR(idx);
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // expected layout of an identification register for a mode
  function automatic csp_byte_t lay(input logic [1:0] m, input logic [7:0] p);
    case (m)
      2'h0:    lay = {2'b00, p[5:0]};
      2'h3:    lay = {p[7:1], 1'b0};
      default: lay = {1'b0, p[6:0]};
    endcase
  endfunction

  // strobe one interval and advance the expected current and average
  task automatic thr(input csp_byte_t c, input logic nz, input bit hold);
    logic [8:0] s;
    model.strobe(c, nz, hold);
    cur_m = (c == 8'h00 && nz) ? 8'h01 : c;
    s     = {1'b0, avg_m} + {1'b0, cur_m};
    avg_m = (s[8:1] == 8'h00 && (avg_m | cur_m) != 8'h00) ? 8'h01 : s[8:1];
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    logic [7:0] idx [6];
    idx = '{8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'hbd};
    foreach (idx[i]) begin
      ahb(1'b0, idx[i], 32'h0, d);
      `CHK(d, 32'h0)
    end
    ahb(1'b1, `CSP_IDX_THR2_AVG, 32'hff, d);
    ahb(1'b0, `CSP_IDX_THR2_AVG, 32'h0, d);
    `CHK(d, 32'h0)
    ahb(1'b0, 8'h70, 32'h0, d);
    `CHK(d, 32'h0)
    $display("test reset done");
  endtask

  task automatic t_pins();
    model.set_pins(8'h5a, 8'h00, 8'h00);
    repeat (4) @(posedge clk_sys);
    ahb(1'b0, `CSP_IDX_PIN_LEVELS, 32'h0, d);
    `CHK(d, 32'h0000_00a5)
    model.set_pins(8'h00, 8'h00, 8'h00);
    repeat (4) @(posedge clk_sys);
    ahb(1'b0, `CSP_IDX_PIN_LEVELS, 32'h0, d);
    `CHK(d, 32'h0000_00ff)
    $display("test pins done");
  endtask

  task automatic t_throttle();
    thr(8'h40, 1'b1, 1'b0);
    ahb(1'b0, `CSP_IDX_THR2_CUR, 32'h0, d);
    `CHK(d[7:0], cur_m)
    ahb(1'b0, `CSP_IDX_THR2_AVG, 32'h0, d);
    `CHK(d[7:0], avg_m)
    thr(8'h00, 1'b1, 1'b0);
    ahb(1'b0, `CSP_IDX_THR2_CUR, 32'h0, d);
    `CHK(d[7:0], 8'h01)
    // back-to-back intervals, each one an update
    thr(8'hff, 1'b1, 1'b1);
    thr(8'h00, 1'b0, 1'b0);
    ahb(1'b0, `CSP_IDX_THR2_AVG, 32'h0, d);
    `CHK(d[7:0], avg_m)
    repeat (8) thr(8'h00, 1'b0, 1'b0);
    ahb(1'b0, `CSP_IDX_THR2_AVG, 32'h0, d);
    `CHK(d[7:0], avg_m)
    $display("test throttle done");
  endtask

  // every layout; software normally picks the newer first mode
  task automatic t_modes();
    model.set_pins(8'hff, 8'hd5, 8'h6b);
    repeat (20) @(posedge clk_sys);
    for (int m = 0; m < 4; m++) begin
      ahb(1'b1, `CSP_IDX_MODE_CTRL, 32'(m), d);
      repeat (3) @(posedge clk_sys);
      ahb(1'b0, `CSP_IDX_MODE_CTRL, 32'h0, d);
      `CHK(d, 32'(m))
      ahb(1'b0, `CSP_IDX_CPU1_VID, 32'h0, d);
      `CHK(d[7:0], lay(m[1:0], 8'hd5))
      ahb(1'b0, `CSP_IDX_CPU2_VID, 32'h0, d);
      `CHK(d[7:0], lay(m[1:0], 8'h6b))
    end
    $display("test modes done");
  endtask

  task automatic t_glitch();
    ahb(1'b1, `CSP_IDX_MODE_CTRL, 32'h0, d);
    model.set_pins(8'hff, 8'h2a, 8'h2a);
    repeat (20) @(posedge clk_sys);
    // two-cycle glitch, shorter than the stable time
    model.set_pins(8'hff, 8'h15, 8'h15);
    @(posedge clk_sys);
    model.set_pins(8'hff, 8'h2a, 8'h2a);
    repeat (20) @(posedge clk_sys);
    ahb(1'b0, `CSP_IDX_CPU1_VID, 32'h0, d);
    `CHK(d[7:0], 8'h2a)
    model.set_pins(8'hff, 8'h15, 8'h15);
    ahb(1'b0, `CSP_IDX_CPU2_VID, 32'h0, d);
    `CHK(d[7:0], 8'h2a)
    repeat (20) @(posedge clk_sys);
    ahb(1'b0, `CSP_IDX_CPU2_VID, 32'h0, d);
    `CHK(d[7:0], 8'h15)
    $display("test glitch done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_pins();
    t_throttle();
    t_modes();
    t_glitch();
    print_verdict();
  end
endmodule
